// ### verilog/tmf_defines.svh
`ifndef TMF_DEFINES_SVH
`define TMF_DEFINES_SVH
// ============================================================
// Register byte offsets on APB
`define TMF_OFF_CNT_HI 8'h00
`define TMF_OFF_CNT_LO 8'h04
`define TMF_OFF_CMP_HI 8'h08
`define TMF_OFF_CMP_LO 8'h0c
`define TMF_OFF_CTL    8'h10
`define TMF_OFF_CSR    8'h14
`define TMF_OFF_IEN    8'h18
// ============================================================
// Reset values and limits
`define TMF_CNT_RST    16'h0000
`define TMF_CMP_RST    16'hffff
`define TMF_REG_RST    8'h00
`define TMF_BYTE_ZERO  8'h00
`define TMF_BYTE_MAX   8'hff
`define TMF_WORD_MAX   16'hffff
// ============================================================
// timer_control_reg fields
`define TMF_HI_OUT_LVL 7
`define TMF_MODE8_BIT  6
`define TMF_HI_SEL     6:4
`define TMF_LO_OUT_LVL 3
`define TMF_LO_SEL     2:0
// Clock select field layout and codes
`define TMF_SEL_ON     2
`define TMF_SEL_CODE   1:0
`define TMF_SEL_D32    2'h0
`define TMF_SEL_D16    2'h1
`define TMF_SEL_D4     2'h2
`define TMF_SEL_W4     2'h3
// ============================================================
// timer_ctrl_status_reg fields
`define TMF_HI_WRAP    7
`define TMF_HI_MATCH   6
`define TMF_HI_WRAP_IE 5
`define TMF_HI_CLR     4
`define TMF_LO_WRAP    3
`define TMF_LO_MATCH   2
`define TMF_LO_WRAP_IE 1
`define TMF_LO_CLR     0
`define TMF_FLAG_MASK  8'hcc
// irq_enable_reg_two fields
`define TMF_IEN_H      0
`define TMF_IEN_L      1
// ============================================================
// Prescaler terminal counts
`define TMF_PRE_D32    5'h1f
`define TMF_PRE_D16    4'hf
`define TMF_PRE_D4     2'h3
`define TMF_WDIV_END   2'h3
`endif

// ### verilog/tmf_pkg.sv
package tmf_pkg;

  // Chip power state
  typedef enum logic [2:0] {
    TMF_ACTIVE,
    TMF_SLEEP,
    TMF_WATCH,
    TMF_SUBACTIVE,
    TMF_SUBSLEEP,
    TMF_STANDBY,
    TMF_MODSTBY
  } tmf_pwr_t;

  typedef struct packed {
    logic [4:0] div;
    logic       sync1;
    logic       sync2;
    logic       wprev;
    logic [1:0] wdiv;
    logic       t32;
    logic       t16;
    logic       t4;
    logic       tw;
  } tmf_pre_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] ocr;
    logic [7:0]  ctl;
    logic [7:0]  csr;
    logic [1:0]  ien;
    logic [7:0]  temp;
    logic [7:0]  armed;
    logic        out_h;
    logic        out_l;
    logic        irq_h;
    logic        irq_l;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tmf_state_t;

endpackage

// ### verilog/tmf_prescale.sv
`timescale 1ns/10ps
`include "tmf_defines.svh"
module tmf_prescale
  import tmf_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Sources
  input  wire logic watch_clk,
  input  wire logic run,
  // One-cycle count pulses
  output logic      tick_d32,
  output logic      tick_d16,
  output logic      tick_d4,
  output logic      tick_w4
);

  tmf_pre_t pre_r;
  tmf_pre_t pre_nxt;
  logic     w_edge;

  // ============================================================
  // Watch clock resynchronisation
  assign w_edge = pre_r.sync2 & ~pre_r.wprev;

  always_comb begin
    pre_nxt       = pre_r;
    pre_nxt.sync1 = watch_clk;
    pre_nxt.sync2 = pre_r.sync1;
    pre_nxt.wprev = pre_r.sync2;
    pre_nxt.div   = pre_r.div + 5'h01;
    if (w_edge) begin
      pre_nxt.wdiv = pre_r.wdiv + 2'h1;
    end
    // Divided system clock and watch clock divided by 4
    pre_nxt.t32 = run & (pre_r.div == `TMF_PRE_D32);
    pre_nxt.t16 = run & (pre_r.div[3:0] == `TMF_PRE_D16);
    pre_nxt.t4  = run & (pre_r.div[1:0] == `TMF_PRE_D4);
    pre_nxt.tw  = run & w_edge & (pre_r.wdiv == `TMF_WDIV_END);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  assign tick_d32 = pre_r.t32;
  assign tick_d16 = pre_r.t16;
  assign tick_d4  = pre_r.t4;
  assign tick_w4  = pre_r.tw;

endmodule

// ### verilog/tmf_timer.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "tmf_defines.svh"
// Operation
// - In 8-bit mode counter and compare bytes are accepted in any order
// - Upper write loads byte latch; lower write loads both bytes together
// - Upper counter read returns it directly; lower byte goes to latch
// - Compare register bytes always read directly, never via the latch
// - High select bit 2 clear: one 16-bit counter; set: two 8-bit counters
// - Reset: counter 0000, compare ffff, control and status registers 00
// - 16-bit uses low select; 8-bit uses high and low selects per half
// - Select among clock/32, /16, /4, watch/4; one count per pulse
// - 16-bit match sets high flag, irq, toggles high pin, may clear
// - 16-bit wrap sets high wrap flag; irq needs both enables
// - 8-bit halves match and wrap independently with own flags and pins
// - Pin drives its output-level bit, then inverts on each match
// - Match fires when counter leaves the matching value on its clock
// - Counter halts in standby states; register writes ignored outside active and subactive
// - Watch clock divided by 4 is resynchronised to the system clock
// - In low-power running modes only watch/4 counts; others stop
// - Control write during a match loads pin from level bit, no toggle
// - Low compare write cancels a coincident match unless equal
// - In 16-bit mode low flags still follow the lower eight bits
// - Low counter write suppresses a coincident overflow
// - Flags clear only by writing 0 after reading 1; writing 1 ignored
module tmf_timer
  import tmf_pkg::*;
(
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // APB slave
  input  wire logic     psel,
  input  wire logic     penable,
  input  wire logic     pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]   prdata,
  output logic          pready,
  output logic          pslverr,
  // Chip state
  input  wire logic     watch_clk,
  input  wire tmf_pwr_t pwr_mode,
  // Timer outputs
  output logic          high_toggle_out,
  output logic          low_toggle_out,
  output logic          timer_irq_high,
  output logic          timer_irq_low
);

  tmf_state_t  st_r;
  tmf_state_t  st_nxt;
  logic        pre_run;
  logic        t32;
  logic        t16;
  logic        t4;
  logic        tw;
  logic        sub_mode;
  logic        mode8;
  logic        reg_ok;
  logic        setup;
  logic        access;
  logic        rd_set;
  logic        mapped;
  logic        wr_cnt_hi;
  logic        wr_cnt_lo;
  logic        wr_cmp_hi;
  logic        wr_cmp_lo;
  logic        wr_ctl;
  logic        wr_csr;
  logic        wr_ien;
  logic        tick_h;
  logic        tick_l;
  logic        hit_h;
  logic        hit_l;
  logic        wrap_h;
  logic        wrap_l;
  logic [7:0]  wd;
  logic [7:0]  rbyte;
  logic [7:0]  set_v;
  logic [7:0]  clr_v;
  logic [15:0] word_w;

  // ============================================================
  // Prescaler
  assign pre_run = (pwr_mode != TMF_STANDBY) &&
                   (pwr_mode != TMF_MODSTBY);

  tmf_prescale u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .watch_clk(watch_clk),
    .run      (pre_run),
    .tick_d32 (t32),
    .tick_d16 (t16),
    .tick_d4  (t4),
    .tick_w4  (tw)
  );

  function automatic logic sel_tick(input logic [2:0] f,
                                    input logic       sub,
                                    input logic       a,
                                    input logic       b,
                                    input logic       c,
                                    input logic       w);
    logic t;
    case (f[`TMF_SEL_CODE])
      `TMF_SEL_D32: t = a;
      `TMF_SEL_D16: t = b;
      `TMF_SEL_D4:  t = c;
      default:      t = w;
    endcase
    if (sub && (f[`TMF_SEL_CODE] != `TMF_SEL_W4)) begin
      t = 1'b0;
    end
    return f[`TMF_SEL_ON] & t;
  endfunction

  // ============================================================
  // Bus decode
  assign sub_mode = (pwr_mode == TMF_WATCH) ||
                    (pwr_mode == TMF_SUBACTIVE) ||
                    (pwr_mode == TMF_SUBSLEEP);
  assign reg_ok   = (pwr_mode == TMF_ACTIVE) ||
                    (pwr_mode == TMF_SUBACTIVE);
  assign mode8    = st_r.ctl[`TMF_MODE8_BIT];
  assign setup    = psel & ~penable;
  assign access   = psel & penable & st_r.pready;
  assign rd_set   = setup & ~pwrite;
  assign wd       = pwdata[7:0];
  assign word_w   = {st_r.temp, wd};
  assign mapped   = (paddr == `TMF_OFF_CNT_HI) || (paddr == `TMF_OFF_CNT_LO) ||
                    (paddr == `TMF_OFF_CMP_HI) || (paddr == `TMF_OFF_CMP_LO) ||
                    (paddr == `TMF_OFF_CTL) || (paddr == `TMF_OFF_CSR) ||
                    (paddr == `TMF_OFF_IEN);
  assign wr_cnt_hi = access & pwrite & reg_ok & (paddr == `TMF_OFF_CNT_HI);
  assign wr_cnt_lo = access & pwrite & reg_ok & (paddr == `TMF_OFF_CNT_LO);
  assign wr_cmp_hi = access & pwrite & reg_ok & (paddr == `TMF_OFF_CMP_HI);
  assign wr_cmp_lo = access & pwrite & reg_ok & (paddr == `TMF_OFF_CMP_LO);
  assign wr_ctl    = access & pwrite & reg_ok & (paddr == `TMF_OFF_CTL);
  assign wr_csr    = access & pwrite & reg_ok & (paddr == `TMF_OFF_CSR);
  assign wr_ien    = access & pwrite & reg_ok & (paddr == `TMF_OFF_IEN);

  // ============================================================
  // Count pulses and match/wrap events
  assign tick_l = sel_tick(st_r.ctl[`TMF_LO_SEL], sub_mode, t32, t16, t4,
                           tw);
  assign tick_h = mode8 ? sel_tick(st_r.ctl[`TMF_HI_SEL], sub_mode, t32, t16,
                                   t4, tw) : tick_l;

  // Match is taken as the counter leaves the equal value
  assign hit_l = tick_l & (st_r.cnt[7:0] == st_r.ocr[7:0]) &
                 ~(wr_cmp_lo & (wd != st_r.cnt[7:0]));
  assign hit_h = mode8 ?
                 (tick_h & (st_r.cnt[15:8] == st_r.ocr[15:8]) &
                  ~(wr_cmp_hi & (wd != st_r.cnt[15:8]))) :
                 (tick_l & (st_r.cnt == st_r.ocr) &
                  ~(wr_cmp_lo & (word_w != st_r.cnt)));
  assign wrap_l = tick_l & (st_r.cnt[7:0] == `TMF_BYTE_MAX) &
                  ~wr_cnt_lo;
  assign wrap_h = mode8 ?
                  (tick_h & (st_r.cnt[15:8] == `TMF_BYTE_MAX) & ~wr_cnt_hi) :
                  (tick_l & (st_r.cnt == `TMF_WORD_MAX) & ~wr_cnt_lo);

  // ============================================================
  // Read data
  always_comb begin
    case (paddr)
      `TMF_OFF_CNT_HI: rbyte = st_r.cnt[15:8];
      `TMF_OFF_CNT_LO: rbyte = mode8 ? st_r.cnt[7:0] : st_r.temp;
      `TMF_OFF_CMP_HI: rbyte = st_r.ocr[15:8];
      `TMF_OFF_CMP_LO: rbyte = st_r.ocr[7:0];
      `TMF_OFF_CTL:    rbyte = st_r.ctl;
      `TMF_OFF_CSR:    rbyte = st_r.csr;
      `TMF_OFF_IEN:    rbyte = {6'h00, st_r.ien};
      default:         rbyte = `TMF_BYTE_ZERO;
    endcase
  end

  // ============================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Counting and clear on match
    if (mode8) begin
      if (hit_h && st_r.csr[`TMF_HI_CLR]) begin
        st_nxt.cnt[15:8] = `TMF_BYTE_ZERO;
      end else if (tick_h) begin
        st_nxt.cnt[15:8] = st_r.cnt[15:8] + 8'h01;
      end
      if (hit_l && st_r.csr[`TMF_LO_CLR]) begin
        st_nxt.cnt[7:0] = `TMF_BYTE_ZERO;
      end else if (tick_l) begin
        st_nxt.cnt[7:0] = st_r.cnt[7:0] + 8'h01;
      end
    end else if (hit_h && st_r.csr[`TMF_HI_CLR]) begin
      st_nxt.cnt = `TMF_CNT_RST;
    end else if (tick_l) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    // Byte accesses through the shared latch
    if (rd_set && !mode8 && (paddr == `TMF_OFF_CNT_HI)) begin
      st_nxt.temp = st_r.cnt[7:0];
    end
    if (wr_cnt_hi) begin
      if (mode8) begin
        st_nxt.cnt[15:8] = wd;
      end else begin
        st_nxt.temp = wd;
      end
    end
    if (wr_cnt_lo) begin
      if (mode8) begin
        st_nxt.cnt[7:0] = wd;
      end else begin
        st_nxt.cnt = word_w;
      end
    end
    if (wr_cmp_hi) begin
      if (mode8) begin
        st_nxt.ocr[15:8] = wd;
      end else begin
        st_nxt.temp = wd;
      end
    end
    if (wr_cmp_lo) begin
      if (mode8) begin
        st_nxt.ocr[7:0] = wd;
      end else begin
        st_nxt.ocr = word_w;
      end
    end
    if (wr_ctl) begin
      st_nxt.ctl = wd;
    end
    if (wr_ien) begin
      st_nxt.ien = wd[1:0];
    end
    // Status flags: write 0 after read 1 clears, a new event wins
    set_v                = `TMF_REG_RST;
    set_v[`TMF_HI_WRAP]  = wrap_h;
    set_v[`TMF_HI_MATCH] = hit_h;
    set_v[`TMF_LO_WRAP]  = wrap_l;
    set_v[`TMF_LO_MATCH] = hit_l;
    clr_v = wr_csr ? (st_r.armed & ~wd & `TMF_FLAG_MASK)
                   : `TMF_REG_RST;
    if (wr_csr) begin
      st_nxt.csr = (wd & ~`TMF_FLAG_MASK) | (st_r.csr & `TMF_FLAG_MASK);
      st_nxt.armed = `TMF_REG_RST;
    end else if (rd_set && (paddr == `TMF_OFF_CSR)) begin
      st_nxt.armed = st_r.armed | (st_r.csr & `TMF_FLAG_MASK);
    end
    st_nxt.csr = (st_nxt.csr & ~clr_v) | set_v;
    // Toggle pins
    if (wr_ctl) begin
      st_nxt.out_h = wd[`TMF_HI_OUT_LVL];
      st_nxt.out_l = wd[`TMF_LO_OUT_LVL];
    end else begin
      st_nxt.out_h = st_r.out_h ^ hit_h;
      st_nxt.out_l = st_r.out_l ^ hit_l;
    end
    // Interrupt requests follow flags and enables
    st_nxt.irq_h = st_nxt.ien[`TMF_IEN_H] &
                   (st_nxt.csr[`TMF_HI_MATCH] |
                    (st_nxt.csr[`TMF_HI_WRAP] &
                     st_nxt.csr[`TMF_HI_WRAP_IE]));
    st_nxt.irq_l = st_nxt.ien[`TMF_IEN_L] &
                   (st_nxt.csr[`TMF_LO_MATCH] |
                    (st_nxt.csr[`TMF_LO_WRAP] &
                     st_nxt.csr[`TMF_LO_WRAP_IE]));
    // APB answer one cycle after setup
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~mapped;
    st_nxt.prdata  = rd_set ? {24'h000000, rbyte} : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{cnt: `TMF_CNT_RST, ocr: `TMF_CMP_RST,
                ctl: `TMF_REG_RST, csr: `TMF_REG_RST,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign high_toggle_out = st_r.out_h;
  assign low_toggle_out  = st_r.out_l;
  assign timer_irq_high  = st_r.irq_h;
  assign timer_irq_low   = st_r.irq_l;

  // ============================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cnt_lo_wr16;
    wr_cnt_lo ##0 !mode8;
  endsequence

  sequence s_cnt_hi_rd16;
    rd_set ##0 (paddr == `TMF_OFF_CNT_HI) ##0 !mode8;
  endsequence

  a_word_write_load: assert property (
    s_cnt_lo_wr16 |=> st_r.cnt == $past(word_w))
    else $error("word write did not load latch and low byte");

  a_hi_read_capture: assert property (
    s_cnt_hi_rd16 |=> (st_r.temp == $past(st_r.cnt[7:0])) &&
                      (prdata[7:0] == $past(st_r.cnt[15:8])))
    else $error("upper counter read did not capture low byte");

  a_cmp_read_direct: assert property (
    (rd_set && paddr == `TMF_OFF_CMP_LO) |=>
      prdata[7:0] == $past(st_r.ocr[7:0]) && st_r.temp == $past(st_r.temp))
    else $error("compare read used the latch");

  a_match_flag_set: assert property (
    (hit_h && !mode8) |=> st_r.csr[`TMF_HI_MATCH])
    else $error("high match flag not set");

  a_wrap_flag_set: assert property (
    wrap_h |=> st_r.csr[`TMF_HI_WRAP])
    else $error("high wrap flag not set");

  a_pin_toggles: assert property (
    (hit_l && !wr_ctl) |=> low_toggle_out != $past(low_toggle_out))
    else $error("low pin did not toggle on match");

  a_ctl_write_pin: assert property (
    wr_ctl |=> high_toggle_out == $past(wd[`TMF_HI_OUT_LVL]))
    else $error("control write did not load high pin");

  a_standby_hold: assert property (
    (pwr_mode == TMF_STANDBY) [*3] ##0 !wr_cnt_lo ##0 !wr_cnt_hi
      |=> $stable(st_r.cnt))
    else $error("counter moved in standby");

  a_flag_no_clear: assert property (
    (st_r.csr[`TMF_HI_MATCH] && !st_r.armed[`TMF_HI_MATCH]) |=>
      st_r.csr[`TMF_HI_MATCH])
    else $error("match flag cleared without prior read");

  a_wrap_suppress: assert property (
    (wr_cnt_lo && !mode8 && !st_r.csr[`TMF_HI_WRAP]) |=>
      !st_r.csr[`TMF_HI_WRAP])
    else $error("overflow not suppressed by counter write");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

endmodule

// ### dv/tmf_cpu_model.sv
`timescale 1ns/10ps
`include "tmf_defines.svh"
// ============================================================
// CPU side: APB master issuing byte transfers
module tmf_cpu_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    // Released lines carry garbage, not the last value
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask

  // Word access as an upper/lower pair, nothing between
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] r;
    logic       e;
    xfer(1'b1, a, v[15:8], r, e);
    xfer(1'b1, a + 8'h04, v[7:0], r, e);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       e;
    xfer(1'b0, a, 8'h00, hi, e);
    xfer(1'b0, a + 8'h04, 8'h00, lo, e);
    v = {hi, lo};
  endtask

  // Flag clear: status read first, then zeros into the flags
  task automatic clr(input logic [7:0] keep);
    logic [7:0] r;
    logic       e;
    xfer(1'b0, `TMF_OFF_CSR, 8'h00, r, e);
    xfer(1'b1, `TMF_OFF_CSR, keep & ~`TMF_FLAG_MASK, r, e);
  endtask
endmodule

// ### dv/tmf_timer_test.sv
`timescale 1ns/10ps
`include "tmf_defines.svh"
module tmf_timer_test import tmf_pkg::*;;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic       er;
  } tmf_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        watch_clk;
  tmf_pwr_t    pwr_mode;
  logic [3:0]  outs;
  logic [7:0]  r;
  logic        e;
  logic [15:0] v1;
  logic [15:0] v2;
  int          bad_count;
  int          check_count;
  int          cyc;

  // ============================================================
  // Ordinary register cases: op, address, data, expected, error
  tmf_row_t rows [0:21] = '{
    {1'b0, `TMF_OFF_CNT_HI, 8'h00, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CNT_LO, 8'h00, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CMP_HI, 8'h00, 8'hff, 1'b0},
    {1'b0, `TMF_OFF_CMP_LO, 8'h00, 8'hff, 1'b0},
    {1'b0, `TMF_OFF_CTL,    8'h00, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CSR,    8'h00, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_IEN,    8'h00, 8'h00, 1'b0},
    {1'b0, 8'h1c,           8'h00, 8'h00, 1'b1},
    {1'b1, `TMF_OFF_CMP_HI, 8'h12, 8'h00, 1'b0},
    {1'b1, `TMF_OFF_CMP_LO, 8'h34, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CMP_LO, 8'h00, 8'h34, 1'b0},
    {1'b0, `TMF_OFF_CMP_HI, 8'h00, 8'h12, 1'b0},
    {1'b1, `TMF_OFF_CNT_HI, 8'hab, 8'h00, 1'b0},
    {1'b1, `TMF_OFF_CNT_LO, 8'hcd, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CNT_HI, 8'h00, 8'hab, 1'b0},
    {1'b0, `TMF_OFF_CNT_LO, 8'h00, 8'hcd, 1'b0},
    {1'b1, `TMF_OFF_CSR,    8'hff, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_CSR,    8'h00, 8'h33, 1'b0},
    {1'b1, `TMF_OFF_IEN,    8'h03, 8'h00, 1'b0},
    {1'b0, `TMF_OFF_IEN,    8'h00, 8'h03, 1'b0},
    {1'b1, `TMF_OFF_CSR,    8'h00, 8'h00, 1'b0},
    {1'b1, `TMF_OFF_IEN,    8'h01, 8'h00, 1'b0}
  };

  logic        high_toggle_out;
  logic        low_toggle_out;
  logic        timer_irq_high;
  logic        timer_irq_low;

  assign outs = {high_toggle_out, low_toggle_out,
                 timer_irq_high, timer_irq_low};

  // ============================================================
  // Clocks, timeout
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  initial watch_clk = 1'b0;
  always #150 watch_clk = ~watch_clk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  tmf_cpu_model cpu (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  tmf_timer dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .watch_clk       (watch_clk),
    .pwr_mode        (pwr_mode),
    .high_toggle_out (high_toggle_out),
    .low_toggle_out  (low_toggle_out),
    .timer_irq_high  (timer_irq_high),
    .timer_irq_low   (timer_irq_low)
  );

  // ============================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] x);
    cpu.xfer(1'b0, a, 8'h00, r, e);
    chk({8'h00, r & m}, {8'h00, x});
  endtask

  task automatic wait_bit(input int i, input logic lvl, input int lim);
    int n;
    n = 0;
    while (outs[i] !== lvl && n < lim) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk({15'h0000, outs[i]}, {15'h0000, lvl});
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    pwr_mode = TMF_ACTIVE;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk({12'h000, outs}, 16'h0000);
    foreach (rows[i]) begin
      cpu.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w) chk({8'h00, r}, {8'h00, rows[i].x});
      chk({15'h0000, e}, {15'h0000, rows[i].er});
    end
    // 16-bit match with clear, pin starts from its level bit
    cpu.wr16(`TMF_OFF_CMP_HI, 16'h0003);
    cpu.wr16(`TMF_OFF_CNT_HI, 16'h0000);
    wr(`TMF_OFF_CSR, 8'h10);
    wr(`TMF_OFF_CTL, 8'h86);
    wait_bit(3, 1'b1, 4);
    wait_bit(3, 1'b0, 100);
    wait_bit(1, 1'b1, 4);
    wr(`TMF_OFF_CTL, 8'h80);
    cpu.rd16(`TMF_OFF_CNT_HI, v1);
    chk({15'h0000, v1 <= 16'h0003}, 16'h0001);
    wr(`TMF_OFF_CSR, 8'h10);
    rdc(`TMF_OFF_CSR, 8'hff, 8'h54);
    wr(`TMF_OFF_CSR, 8'h10);
    rdc(`TMF_OFF_CSR, 8'hff, 8'h10);
    wait_bit(1, 1'b0, 4);
    // 16-bit wrap
    cpu.wr16(`TMF_OFF_CMP_HI, 16'h8000);
    cpu.wr16(`TMF_OFF_CNT_HI, 16'hfffd);
    wr(`TMF_OFF_CSR, 8'h20);
    wr(`TMF_OFF_CTL, 8'h06);
    wait_bit(1, 1'b1, 100);
    wr(`TMF_OFF_CTL, 8'h00);
    rdc(`TMF_OFF_CSR, 8'hf8, 8'ha8);
    cpu.clr(8'h00);
    rdc(`TMF_OFF_CSR, 8'hff, 8'h00);
    // 8-bit mode, two halves on different clocks, lower bytes written before upper
    wr(`TMF_OFF_CTL, 8'h40);
    wr(`TMF_OFF_CMP_LO, 8'h02);
    wr(`TMF_OFF_CMP_HI, 8'h05);
    wr(`TMF_OFF_CNT_LO, 8'h00);
    wr(`TMF_OFF_CNT_HI, 8'h00);
    rdc(`TMF_OFF_CMP_LO, 8'hff, 8'h02);
    wr(`TMF_OFF_CSR, 8'h11);
    wr(`TMF_OFF_IEN, 8'h03);
    wr(`TMF_OFF_CTL, 8'he5);
    wait_bit(3, 1'b0, 100);
    wait_bit(2, 1'b1, 200);
    wait_bit(0, 1'b1, 4);
    wr(`TMF_OFF_CTL, 8'h40);
    rdc(`TMF_OFF_CSR, 8'hcc, 8'h44);
    cpu.clr(8'h00);
    // Power states
    wr(`TMF_OFF_CTL, 8'h00);
    cpu.wr16(`TMF_OFF_CNT_HI, 16'h0000);
    wr(`TMF_OFF_CTL, 8'h06);
    @(posedge pclk) pwr_mode <= TMF_STANDBY;
    cpu.rd16(`TMF_OFF_CNT_HI, v1);
    repeat (20) @(posedge pclk);
    @(posedge pclk) pwr_mode <= TMF_MODSTBY;
    repeat (20) @(posedge pclk);
    cpu.rd16(`TMF_OFF_CNT_HI, v2);
    chk(v2, v1);
    wr(`TMF_OFF_CMP_LO, 8'h55);
    rdc(`TMF_OFF_CMP_LO, 8'hff, 8'h02);
    @(posedge pclk) pwr_mode <= TMF_SUBACTIVE;
    cpu.rd16(`TMF_OFF_CNT_HI, v1);
    repeat (40) @(posedge pclk);
    cpu.rd16(`TMF_OFF_CNT_HI, v2);
    chk(v2, v1);
    wr(`TMF_OFF_CTL, 8'h07);
    repeat (600) @(posedge pclk);
    cpu.rd16(`TMF_OFF_CNT_HI, v2);
    chk({15'h0000, v2 > v1}, 16'h0001);
    // Mid-run reset brings counter, compare, control and status back
    presetn <= 1'b0;
    @(posedge pclk);
    chk({12'h000, outs}, 16'h0000);
    presetn <= 1'b1;
    cpu.rd16(`TMF_OFF_CNT_HI, v1);
    chk(v1, 16'h0000);
    cpu.rd16(`TMF_OFF_CMP_HI, v2);
    chk(v2, 16'hffff);
    rdc(`TMF_OFF_CTL, 8'hff, 8'h00);
    rdc(`TMF_OFF_CSR, 8'hff, 8'h00);
    report_and_stop();
  end
endmodule
